//--- core/irmask_cfg.svh
`ifndef IRMASK_CFG_SVH
`define IRMASK_CFG_SVH
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define IRM_CNT_W 16
`define IRM_ZERO 16'h0000
`define IRM_ALL1 16'hffff
`define IRM_ONE 16'h0001
`define IRM_MASTER_MODE 16'h0801
`define IRM_SLAVE_MODE 16'h0409
// ----------------------------------------
// channel numbers inside unit 0
// ----------------------------------------
`define IRM_MASK_MASTER_CH 3'h2
`define IRM_MASK_SLAVE_CH 3'h3
`define IRM_CAR_MASTER_CH 3'h6
`define IRM_CAR_SLAVE_CH 3'h7
`endif

//--- core/irmask_pkg.sv
`default_nettype none
package irmask_pkg;
    typedef logic [15:0] irmask_word_t;
    // one master/slave pair: period and width settings
    typedef struct packed {
        irmask_word_t period;
        irmask_word_t width;
    } irmask_pair_cfg_t;
    // trigger bits written by software in a single write
    typedef struct packed {
        logic master_start_trigger;
        logic slave_start_trigger;
        logic master_stop_trigger;
        logic slave_stop_trigger;
    } irmask_trig_t;
    typedef enum logic [2:0] {
        IRM_IDLE = 3'b001,
        IRM_ARM = 3'b010,
        IRM_RUN = 3'b100
    } irmask_state_t;
endpackage : irmask_pkg
`default_nettype wire

//--- core/irmask_pair.sv
`include "irmask_cfg.svh"
`default_nettype none
// one master/slave pair: master counts period down, slave one-shot width
module irmask_pair
    import irmask_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic run,
    input wire logic arm,
    input wire irmask_pair_cfg_t cfg,
    output logic master_tick,
    output irmask_word_t master_counter,
    output irmask_word_t slave_counter,
    output logic slave_wave_out
);
    // ----------------------------------------
    // counters
    // ----------------------------------------
    irmask_word_t mcnt_r, mcnt_nxt, scnt_r, scnt_nxt;
    logic wave_r, wave_nxt, tick_r, tick_nxt;

    function automatic irmask_word_t dec(input irmask_word_t v);
        dec = v - `IRM_ONE;
    endfunction : dec

    always_comb begin
        mcnt_nxt = mcnt_r;
        scnt_nxt = scnt_r;
        wave_nxt = wave_r;
        tick_nxt = 1'b0;
        if (arm) begin
            // first period boundary right at start
            mcnt_nxt = cfg.period;
            scnt_nxt = cfg.width;
            wave_nxt = (cfg.width != `IRM_ZERO);
            tick_nxt = 1'b1;
        end else if (run) begin
            if (mcnt_r == `IRM_ZERO) begin
                // new settings are loaded only at the boundary
                mcnt_nxt = cfg.period;
                scnt_nxt = cfg.width;
                wave_nxt = (cfg.width != `IRM_ZERO) &&
                           (cfg.period != `IRM_ZERO);
                tick_nxt = 1'b1;
            end else begin
                mcnt_nxt = dec(mcnt_r);
                if (scnt_r != `IRM_ALL1) begin
                    scnt_nxt = dec(scnt_r);
                    // width hits zero: slave goes low, then parks at ffff
                    if (dec(scnt_r) == `IRM_ZERO) begin
                        wave_nxt = 1'b0;
                    end
                end
            end
        end else begin
            wave_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mcnt_r <= `IRM_ZERO;
            scnt_r <= `IRM_ALL1;
            wave_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            mcnt_r <= mcnt_nxt;
            scnt_r <= scnt_nxt;
            wave_r <= wave_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign master_tick = tick_r;
    assign master_counter = mcnt_r;
    assign slave_counter = scnt_r;
    assign slave_wave_out = wave_r;
endmodule : irmask_pair
`default_nettype wire

//--- core/irmask_top.sv
`include "irmask_cfg.svh"
`default_nettype none
// Contract
// - start triggers written together; device clears trigger bits itself
// - start sets enabled status of master and both slaves
// - mask master start raises mask period interrupt; slave then counts
// - mask slave gives mask wave, carrier slave gives carrier wave
// - pin is mask AND carrier; low once mask width counter expires
// - mask period interrupt each time mask master counter reaches zero
// - stop triggers written together after interrupt; device clears them
// - stop clears enabled status bits and halts counting
// - stopping forces slave outputs low
// - master and slave counters readable at any time
// - mask uses channels 2 and 3, carrier channels 6 and 7 of unit 0
// - remote path valid only when output select is 1
module irmask_top
    import irmask_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic timer_unit_clock_gate,
    input wire logic remote_output_select,
    input wire logic wr_en,
    input wire irmask_pair_cfg_t mask_cfg_in,
    input wire irmask_pair_cfg_t carrier_cfg_in,
    input wire logic wr_mask_period,
    input wire logic wr_mask_width,
    input wire logic wr_carrier_period,
    input wire logic wr_carrier_width,
    input wire irmask_trig_t trig_in,
    input wire logic trig_wr,
    input wire logic slave_output_enable,
    input wire logic master_output_enable,
    input wire irmask_word_t master_mode_reg,
    input wire irmask_word_t slave_mode_reg,
    output logic master_enabled_status,
    output logic [1:0] slave_enabled_status,
    output logic mask_period_irq,
    output logic mask_wave_out,
    output logic carrier_wave_out,
    output logic remote_output_pin,
    output irmask_word_t mask_period_counter,
    output irmask_word_t mask_width_counter,
    output irmask_word_t carrier_period_counter,
    output irmask_word_t carrier_width_counter,
    output logic mode_ok,
    output logic [2:0] mask_master_channel,
    output logic [2:0] carrier_master_channel
);
    // ----------------------------------------
    // settings registers, write only with clock gate on
    // ----------------------------------------
    irmask_pair_cfg_t mask_cfg_r, mask_cfg_nxt;
    irmask_pair_cfg_t car_cfg_r, car_cfg_nxt;
    logic wr_ok;
    assign wr_ok = wr_en && timer_unit_clock_gate;

    always_comb begin
        mask_cfg_nxt = mask_cfg_r;
        car_cfg_nxt = car_cfg_r;
        if (!timer_unit_clock_gate) begin
            // gated unit sits in reset; settings must be redone
            mask_cfg_nxt = '0;
            car_cfg_nxt = '0;
        end else if (wr_ok) begin
            if (wr_mask_period) mask_cfg_nxt.period = mask_cfg_in.period;
            if (wr_mask_width) mask_cfg_nxt.width = mask_cfg_in.width;
            if (wr_carrier_period) car_cfg_nxt.period = carrier_cfg_in.period;
            if (wr_carrier_width) car_cfg_nxt.width = carrier_cfg_in.width;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_cfg_r <= '0;
            car_cfg_r <= '0;
        end else begin
            mask_cfg_r <= mask_cfg_nxt;
            car_cfg_r <= car_cfg_nxt;
        end
    end

    // ----------------------------------------
    // run control
    // ----------------------------------------
    irmask_state_t st_r, st_nxt;
    logic start_req, stop_req;
    logic en_r, en_nxt, slv_en_r, slv_en_nxt;
    logic run, arm;
    // both trigger bits must be set in the same write
    assign start_req = trig_wr && wr_ok && trig_in.master_start_trigger &&
                       trig_in.slave_start_trigger;
    assign stop_req = trig_wr && wr_ok && trig_in.master_stop_trigger &&
                      trig_in.slave_stop_trigger;

    always_comb begin
        st_nxt = st_r;
        en_nxt = en_r;
        slv_en_nxt = slv_en_r;
        case (st_r)
            IRM_IDLE: begin
                // start needs slave output on, master output off
                if (start_req && slave_output_enable &&
                    !master_output_enable) begin
                    st_nxt = IRM_ARM;
                    en_nxt = 1'b1;
                    slv_en_nxt = 1'b1;
                end
            end
            IRM_ARM: begin
                st_nxt = IRM_RUN;
            end
            IRM_RUN: begin
            end
            default: begin
                st_nxt = IRM_IDLE;
            end
        endcase
        // stop wins over everything, also while arming
        if (stop_req || !timer_unit_clock_gate) begin
            st_nxt = IRM_IDLE;
            en_nxt = 1'b0;
            slv_en_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= IRM_IDLE;
            en_r <= 1'b0;
            slv_en_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            en_r <= en_nxt;
            slv_en_r <= slv_en_nxt;
        end
    end

    assign arm = (st_r == IRM_ARM);
    assign run = (st_r == IRM_RUN);

    // ----------------------------------------
    // the two channel pairs
    // ----------------------------------------
    logic mask_tick, car_tick, mask_wave, car_wave;
    irmask_word_t mpc, mwc, cpc, cwc;

    // mask pair: channels 2 and 3
    irmask_pair u_mask (
        .clk(clk),
        .reset(reset),
        .run(run),
        .arm(arm),
        .cfg(mask_cfg_r),
        .master_tick(mask_tick),
        .master_counter(mpc),
        .slave_counter(mwc),
        .slave_wave_out(mask_wave)
    );

    // carrier pair: channels 6 and 7
    irmask_pair u_car (
        .clk(clk),
        .reset(reset),
        .run(run),
        .arm(arm),
        .cfg(car_cfg_r),
        .master_tick(car_tick),
        .master_counter(cpc),
        .slave_counter(cwc),
        .slave_wave_out(car_wave)
    );

    // ----------------------------------------
    // outputs, all registered
    // ----------------------------------------
    logic irq_r, mwave_r, cwave_r, pin_r, mode_ok_r;
    // channel numbers in flops too, so every output is registered
    logic [2:0] mch_r, cch_r;
    irmask_word_t mpc_r, mwc_r, cpc_r, cwc_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_r <= 1'b0;
            mwave_r <= 1'b0;
            cwave_r <= 1'b0;
            pin_r <= 1'b0;
            mode_ok_r <= 1'b0;
            mpc_r <= `IRM_ZERO;
            mwc_r <= `IRM_ALL1;
            cpc_r <= `IRM_ZERO;
            cwc_r <= `IRM_ALL1;
            mch_r <= `IRM_MASK_MASTER_CH;
            cch_r <= `IRM_CAR_MASTER_CH;
        end else begin
            // tick marks start and every master reload
            irq_r <= mask_tick;
            mwave_r <= mask_wave;
            cwave_r <= car_wave;
            // pin is held low when the remote path is not selected
            pin_r <= remote_output_select && mask_wave && car_wave;
            mode_ok_r <= (master_mode_reg == `IRM_MASTER_MODE) &&
                         (slave_mode_reg == `IRM_SLAVE_MODE);
            // shadow copies trail the live counters by one cycle
            mpc_r <= mpc;
            mwc_r <= mwc;
            cpc_r <= cpc;
            cwc_r <= cwc;
            mch_r <= `IRM_MASK_MASTER_CH;
            cch_r <= `IRM_CAR_MASTER_CH;
        end
    end

    assign master_enabled_status = en_r;
    assign slave_enabled_status = {slv_en_r, slv_en_r};
    assign mask_period_irq = irq_r;
    assign mask_wave_out = mwave_r;
    assign carrier_wave_out = cwave_r;
    assign remote_output_pin = pin_r;
    assign mask_period_counter = mpc_r;
    assign mask_width_counter = mwc_r;
    assign carrier_period_counter = cpc_r;
    assign carrier_width_counter = cwc_r;
    assign mode_ok = mode_ok_r;
    assign mask_master_channel = mch_r;
    assign carrier_master_channel = cch_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_start_enables: assert property (
        start_req && slave_output_enable && !master_output_enable &&
        !stop_req && timer_unit_clock_gate && st_r == IRM_IDLE
        |=> master_enabled_status && slave_enabled_status == 2'b11)
        else $error("start did not set enabled status");
    a_stop_clears: assert property (
        stop_req |=> !master_enabled_status && st_r == IRM_IDLE)
        else $error("stop did not clear enabled status");
    a_stop_low: assert property (
        stop_req |=> ##1 !mask_wave && !car_wave ##1 !remote_output_pin)
        else $error("slave output not low after stop");
    a_pin_and: assert property (
        remote_output_pin |-> $past(mask_wave) && $past(car_wave))
        else $error("pin high without mask and carrier");
    a_pin_select: assert property (
        !remote_output_select |=> !remote_output_pin)
        else $error("pin high with remote path off");
    a_irq_zero: assert property (
        run && mpc == `IRM_ZERO |=> ##1 mask_period_irq)
        else $error("no irq at mask counter zero");
    a_irq_start: assert property (
        arm |=> ##1 mask_period_irq)
        else $error("no irq at start");
    a_width_low: assert property (
        run && mwc == `IRM_ONE && mpc != `IRM_ZERO |=> !mask_wave)
        else $error("mask wave not low at width end");
    a_boundary_load: assert property (
        run && mpc != `IRM_ZERO |=> mpc == $past(mpc) - `IRM_ONE)
        else $error("period counter jumped mid period");
    a_gate_wr: assert property (
        !timer_unit_clock_gate |=> mask_cfg_r == '0 && car_cfg_r == '0)
        else $error("settings kept while gated");
    a_single_trig: assert property (
        trig_wr && wr_ok && trig_in.master_start_trigger &&
        !trig_in.slave_start_trigger && !master_enabled_status
        |=> !master_enabled_status)
        else $error("single start bit started the channels");
    a_idle_no_tick: assert property (
        $past(st_r) == IRM_IDLE |-> !mask_tick && !car_tick)
        else $error("master reload while stopped");
    a_wave_copy: assert property (
        mask_wave_out == $past(mask_wave) &&
        carrier_wave_out == $past(car_wave))
        else $error("wave outputs not registered copies");
    a_irq_source: assert property (
        mask_period_irq |-> $past(mask_tick))
        else $error("irq without mask master reload");
    a_width_park: assert property (
        run && mwc == `IRM_ZERO && mpc != `IRM_ZERO |=> mwc == `IRM_ALL1)
        else $error("width counter did not park at ffff");
    a_stop_hold: assert property (
        !run && !arm |=> mpc == $past(mpc))
        else $error("period counter moved while stopped");

    c_start: cover property (arm ##1 run);
    c_irq: cover property (run ##1 mask_period_irq);
    c_pin: cover property (remote_output_pin ##[1:50] !remote_output_pin);
    c_stop: cover property (run ##1 stop_req);
    c_zero_duty: cover property (run && mask_cfg_r.period == `IRM_ZERO);
endmodule : irmask_top
`default_nettype wire

//--- verification/irmask_led_model.sv
`default_nettype none
// ----------------------------------------
// infrared emitter: counts light flashes
// ----------------------------------------
module irmask_led_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic led_drive,
    output var int flashes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic led_prev;
    // a flash is a rising edge; level width is not the emitter's concern
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            led_prev <= 1'b0;
            flashes <= 0;
        end else begin
            led_prev <= led_drive;
            if (led_drive && !led_prev) begin
                flashes <= flashes + 1;
            end
        end
    end
endmodule : irmask_led_model
`default_nettype wire

//--- verification/ir_remote_mask_carrier_output_bench.sv
`default_nettype none
module ir_remote_mask_carrier_output_bench import irmask_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset, timer_unit_clock_gate, remote_output_select, wr_en;
    irmask_pair_cfg_t mask_cfg_in, carrier_cfg_in;
    logic wr_mask_period, wr_mask_width, wr_carrier_period;
    logic wr_carrier_width, trig_wr, slave_output_enable;
    logic master_output_enable, master_enabled_status, mask_period_irq;
    logic mask_wave_out, carrier_wave_out, remote_output_pin, mode_ok;
    logic [3:0] wr_s;
    logic [1:0] slave_enabled_status;
    logic [2:0] mask_master_channel, carrier_master_channel;
    irmask_trig_t trig_in;
    irmask_word_t master_mode_reg, slave_mode_reg, snap;
    irmask_word_t mask_period_counter, mask_width_counter;
    irmask_word_t carrier_period_counter, carrier_width_counter;
    int n_errors = 0, compares = 0, flashes, wm, pc1, wc, cnt[6];
    int car_tab[6] = '{2, 3, 4, 6, 8, 12};
    logic [31:0] seed_use;
    assign {wr_mask_period, wr_mask_width} = wr_s[3:2];
    assign {wr_carrier_period, wr_carrier_width} = wr_s[1:0];
    always #12.5 clk = ~clk;
    irmask_top irmask_top_inst (
        .clk, .reset, .timer_unit_clock_gate, .remote_output_select, .wr_en,
        .mask_cfg_in, .carrier_cfg_in, .wr_mask_period, .wr_mask_width,
        .wr_carrier_period, .wr_carrier_width, .trig_in, .trig_wr,
        .slave_output_enable, .master_output_enable, .master_mode_reg,
        .slave_mode_reg, .master_enabled_status, .slave_enabled_status,
        .mask_period_irq, .mask_wave_out, .carrier_wave_out,
        .remote_output_pin, .mask_period_counter, .mask_width_counter,
        .carrier_period_counter, .carrier_width_counter, .mode_ok,
        .mask_master_channel, .carrier_master_channel
    );
    irmask_led_model irmask_led_model_inst (
        .clk, .reset, .led_drive(remote_output_pin), .flashes
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // carrier and mask restart together, so overlap per mask period is fixed
    function automatic int exp_and(int w, int p, int c);
        int s = 0;
        for (int t = 0; t < w; t++) begin
            s += int'((t % p) < c);
        end
        return s;
    endfunction : exp_and
    task automatic strobe(input logic [3:0] s);
        @(negedge clk);
        wr_s = s;
        @(negedge clk);
        wr_s = 4'h0;
    endtask : strobe
    task automatic pulse_trig(input logic [3:0] t);
        @(negedge clk);
        trig_in = irmask_trig_t'(t);
        trig_wr = 1'b1;
        @(negedge clk);
        trig_wr = 1'b0;
    endtask : pulse_trig
    task automatic wait_irq(input int lim);
        int k = 0;
        do begin
            @(negedge clk);
            k++;
            if (k > lim) begin
                n_errors++;
                $display("unexpected irq wait: expected 1 seen 0");
                complete_run();
            end
        end while (mask_period_irq !== 1'b1);
    endtask : wait_irq
    // whole periods in the window make the counts phase independent
    task automatic measure(input int n);
        logic pm, pc;
        pm = mask_wave_out;
        pc = carrier_wave_out;
        cnt = '{default: 0};
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cnt[0] += int'(mask_wave_out === 1'b1);
            cnt[1] += int'(carrier_wave_out === 1'b1);
            cnt[2] += int'(remote_output_pin === 1'b1);
            cnt[3] += int'((mask_wave_out & carrier_wave_out) === 1'b1);
            cnt[4] += int'(mask_period_irq === 1'b1);
            cnt[5] += int'(remote_output_pin === 1'b1 && !(pm & pc)
                && !(mask_wave_out & carrier_wave_out));
            pm = mask_wave_out;
            pc = carrier_wave_out;
        end
    endtask : measure
    // called where the irq stands: shadows hold the values just reloaded
    task automatic check_run(input logic pin_on);
        chk("mask period count", 16'h0017, mask_period_counter);
        chk("mask width count", wm, mask_width_counter);
        chk("carrier period count", pc1 - 1, carrier_period_counter);
        chk("carrier width count", wc, carrier_width_counter);
        chk("mode kept", 1, mode_ok);
        measure(48);
        chk("irq count", 2, cnt[4]);
        chk("mask high", 2 * wm, cnt[0]);
        chk("carrier high", 48 / pc1 * wc, cnt[1]);
        chk("wave and", 2 * exp_and(wm, pc1, wc), cnt[3]);
        chk("pin high", pin_on ? cnt[3] : 0, cnt[2]);
        chk("pin stray", 0, cnt[5]);
    endtask : check_run
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed_use = $urandom(32'h5a9a);
        reset = 1'b1;
        timer_unit_clock_gate = 1'b0;
        remote_output_select = 1'b1;
        wr_en = 1'b1;
        wr_s = 4'h0;
        trig_in = '0;
        trig_wr = 1'b0;
        slave_output_enable = 1'b1;
        master_output_enable = 1'b0;
        master_mode_reg = 16'h0409;
        slave_mode_reg = 16'h0409;
        pc1 = car_tab[$urandom_range(0, 5)];
        wc = $urandom_range(1, pc1 - 1);
        wm = $urandom_range(1, 22);
        mask_cfg_in = '{16'h0017, 16'(wm)};
        carrier_cfg_in = '{16'(pc1 - 1), 16'(wc)};
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk("width counter", 16'hffff, mask_width_counter);
        chk("period counter", 16'h0000, mask_period_counter);
        chk("mask channel", 3'h2, mask_master_channel);
        chk("carrier channel", 3'h6, carrier_master_channel);
        strobe(4'hf);
        pulse_trig(4'hc);
        repeat (3) @(negedge clk);
        chk("gated start", 0, master_enabled_status);
        chk("mode bad", 0, mode_ok);
        master_mode_reg = 16'h0801;
        timer_unit_clock_gate = 1'b1;
        strobe(4'hf);
        chk("mode ok", 1, mode_ok);
        pulse_trig(4'h8);
        repeat (3) @(negedge clk);
        chk("single bit start", 0, master_enabled_status);
        master_output_enable = 1'b1;
        pulse_trig(4'hc);
        repeat (3) @(negedge clk);
        chk("master enable start", 0, master_enabled_status);
        master_output_enable = 1'b0;
        pulse_trig(4'hc);
        @(negedge clk);
        chk("master status", 1, master_enabled_status);
        chk("slave status", 2'b11, slave_enabled_status);
        wait_irq(6);
        check_run(1'b1);
        snap = mask_period_counter;
        @(negedge clk);
        chk("counter moves", 1, snap !== mask_period_counter);
        for (int i = 0; i < 3; i++) begin
            wait_irq(30);
            wm = (i == 0) ? 1 : $urandom_range(1, 22);
            mask_cfg_in.width = 16'(wm);
            remote_output_select = (i != 1);
            strobe(4'h4);
            wait_irq(30);
            wait_irq(30);
            check_run(i != 1);
        end
        remote_output_select = 1'b1;
        wait_irq(30);
        mask_cfg_in.period = 16'h0000;
        strobe(4'h8);
        wait_irq(30);
        wait_irq(30);
        measure(24);
        chk("zero duty mask", 0, cnt[0]);
        chk("zero duty pin", 0, cnt[2]);
        pulse_trig(4'h3);
        @(negedge clk);
        chk("stopped status", 0, master_enabled_status);
        chk("stopped slaves", 2'b00, slave_enabled_status);
        repeat (2) @(negedge clk);
        chk("mask wave stop", 0, mask_wave_out);
        chk("carrier wave stop", 0, carrier_wave_out);
        chk("pin stop", 0, remote_output_pin);
        snap = mask_period_counter;
        measure(24);
        chk("irq after stop", 0, cnt[4]);
        chk("counter halted", snap, mask_period_counter);
        chk("led flashed", 1, flashes > 0);
        timer_unit_clock_gate = 1'b0;
        repeat (2) @(negedge clk);
        timer_unit_clock_gate = 1'b1;
        mask_cfg_in.period = 16'h0017;
        strobe(4'hf);
        pulse_trig(4'hc);
        wait_irq(8);
        check_run(1'b1);
        complete_run();
    end
endmodule : ir_remote_mask_carrier_output_bench
`default_nettype wire
